/* logic/prot_i2c_pkg.sv */
// shared constants and types for the protection switch serial target
package prot_i2c_pkg;
  // timing
  localparam int CLK_PERIOD_NS = 5;
  localparam int SPIKE_NS = 50;
  localparam int SPIKE_CYCLES = (SPIKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // target address: fixed upper bits, factory middle bits, pin-selected lsb
  localparam logic [3:0] ADDR_UPPER = 4'h5;
  localparam logic [1:0] ADDR_MID = 2'h0;
  localparam logic [7:0] GENERAL_CALL = 8'h00;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  // register indexes on the serial bus
  localparam logic [7:0] REG_MASK = 8'h00;
  localparam logic [7:0] REG_CONFIG = 8'h01;
  localparam logic [7:0] REG_IDENT = 8'h02;
  localparam logic [7:0] REG_STAT0 = 8'h03;
  localparam logic [7:0] REG_STAT1 = 8'h04;
  localparam logic [7:0] REG_STAT2 = 8'h05;
  localparam logic [7:0] MASK_RESET = 8'h00;
  localparam logic [7:0] CONFIG_RESET = 8'h1F;
  localparam logic [7:0] STAT_RESET = 8'h00;
  // mask field positions
  localparam int MASK_UV = 0;
  localparam int MASK_OV = 1;
  localparam int MASK_OC = 2;
  localparam int MASK_VIN = 3;
  localparam int MASK_VDD = 4;
  localparam int MASK_TS = 5;
  localparam int MASK_ACC = 6;
  // device-level status positions
  localparam int ST_UVDD = 0;
  localparam int ST_OVDD = 1;
  localparam int ST_UVIN = 2;
  localparam int ST_OVIN = 3;
  localparam int ST_ACC = 4;
  localparam int ST_ISET = 5;
  // per-channel status nibble positions
  localparam int CH_UV = 0;
  localparam int CH_OV = 1;
  localparam int CH_OC = 2;
  localparam int CH_TS = 3;
  localparam int NUM_CHAN = 4;

  typedef enum logic [3:0] {
    BUS_IDLE = 4'h0,
    BUS_ADDR = 4'h1,
    BUS_ADDR_ACK = 4'h2,
    BUS_REG = 4'h3,
    BUS_REG_ACK = 4'h4,
    BUS_WDATA = 4'h5,
    BUS_WDATA_ACK = 4'h6,
    BUS_RDATA = 4'h7,
    BUS_RDATA_ACK = 4'h8,
    BUS_IGNORE = 4'h9
  } bus_state_e;
endpackage

/* logic/prot_pin_filter.sv */
// two-flop synchroniser and spike filter for asynchronous pins
`timescale 1ns/100ps
module prot_pin_filter #(
  parameter int W = 4,
  parameter int CNT = prot_i2c_pkg::SPIKE_CYCLES,
  parameter logic [W-1:0] RESET_LVL = '0
) (
  // clock, reset, enable
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic clkEn,
  // pins in, clean levels out
  input wire logic [W-1:0] rawIn,
  output logic [W-1:0] level
);
  import prot_i2c_pkg::*;

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] lvl;
    logic [W-1:0][7:0] cnt;
  } filt_s;

  filt_s r, n;

  always_comb begin
    n = r;
    n.s1 = rawIn;
    n.s2 = r.s1;
    // a new level is taken only once it has stood for the whole spike window
    for (int i = 0; i < W; i++) begin
      if (r.s2[i] == r.lvl[i]) begin
        n.cnt[i] = 8'h00;
      end else if (r.cnt[i] == 8'(CNT - 1)) begin
        n.lvl[i] = r.s2[i];
        n.cnt[i] = 8'h00;
      end else begin
        n.cnt[i] = r.cnt[i] + 8'h01;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      r <= '{s1: RESET_LVL, s2: RESET_LVL, lvl: RESET_LVL, cnt: '0};
    end else if (clkEn) begin
      r <= n;
    end
  end

  assign level = r.lvl;
endmodule // prot_pin_filter

/* logic/prot_regs.sv */
// configuration, latched status and interrupt gating
`timescale 1ns/100ps
module prot_regs #(
  parameter logic [7:0] IDENT_VALUE = 8'h3C // arbitrary value
) (
  // clock, reset, enable
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic clkEn,
  // access from the serial engine
  input wire logic wrStb,
  input wire logic rdStb,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] wrData,
  output logic [7:0] rdData,
  // fault sources and results
  input wire logic [7:0] devFault,
  input wire logic [15:0] chanFault,
  output logic [3:0] cfgEnable,
  output logic intAsserted
);
  import prot_i2c_pkg::*;

  typedef struct packed {
    logic [7:0] mask;
    logic [7:0] cfg;
    logic [7:0] stat0;
    logic [7:0] stat1;
    logic [7:0] stat2;
    logic intAct;
  } regs_s;

  regs_s r, n;
  logic [15:0] chanStat;
  logic pend;

  assign chanStat = {r.stat2, r.stat1};

  always_comb begin
    pend = (r.stat0[ST_UVDD] | r.stat0[ST_OVDD]) & ~r.mask[MASK_VDD];
    pend = pend | ((r.stat0[ST_UVIN] | r.stat0[ST_OVIN]) & ~r.mask[MASK_VIN]);
    pend = pend | (r.stat0[ST_ACC] & ~r.mask[MASK_ACC]) | r.stat0[ST_ISET];
    for (int c = 0; c < NUM_CHAN; c++) begin
      pend = pend | (chanStat[4*c+CH_UV] & ~r.mask[MASK_UV]);
      pend = pend | (chanStat[4*c+CH_OV] & ~r.mask[MASK_OV]);
      pend = pend | (chanStat[4*c+CH_OC] & ~r.mask[MASK_OC]);
      pend = pend | (chanStat[4*c+CH_TS] & ~r.mask[MASK_TS]);
    end
  end

  always_comb begin
    n = r;
    // a read clears a status register; a fault present that cycle sets it again
    n.stat0 = ((rdStb && regAddr == REG_STAT0) ? STAT_RESET : r.stat0) | devFault; // RULE_24
    n.stat1 = ((rdStb && regAddr == REG_STAT1) ? STAT_RESET : r.stat1) | chanFault[7:0];
    n.stat2 = ((rdStb && regAddr == REG_STAT2) ? STAT_RESET : r.stat2) | chanFault[15:8];
    if (wrStb && regAddr == REG_MASK) begin
      n.mask = wrData;
    end
    if (wrStb && regAddr == REG_CONFIG) begin
      n.cfg = wrData; // RULE_20
    end
    n.intAct = pend; // RULE_24
  end

  always_comb begin
    case (regAddr)
      REG_MASK: rdData = r.mask;
      REG_CONFIG: rdData = r.cfg;
      REG_IDENT: rdData = IDENT_VALUE;
      REG_STAT0: rdData = r.stat0;
      REG_STAT1: rdData = r.stat1;
      REG_STAT2: rdData = r.stat2;
      default: rdData = 8'h00;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      r <= '{mask: MASK_RESET, cfg: CONFIG_RESET, stat0: STAT_RESET, stat1: STAT_RESET,
             stat2: STAT_RESET, intAct: 1'b0};
    end else if (clkEn) begin
      r <= n;
    end
  end

  assign cfgEnable = r.cfg[NUM_CHAN-1:0];
  assign intAsserted = r.intAct;
endmodule // prot_regs

/* logic/camera_protector_i2c_target.sv */
// two-wire serial target port with enable edges and fault interrupt pin
// Notes on behaviour
// RULE_01 - one bit per clock period; data sampled while clock is high
// RULE_02 - data falling while clock high starts a new transfer
// RULE_03 - data rising while clock high is a stop; transfer ends, bus released
// RULE_04 - repeated start restarts address reception with no idle needed
// RULE_05 - every byte is eight bits plus a ninth acknowledge clock
// RULE_06 - stop aborts at any bit, unless in the same high pulse as start
// RULE_07 - the clock line is never held low by this block
// RULE_08 - the all-zero general call address is never acknowledged
// RULE_09 - first byte: seven address bits then direction bit in the lsb
// RULE_10 - direction one reads from the device, zero writes to it
// RULE_11 - the address byte is the first byte after every start
// RULE_12 - address is 0101 00 plus the address-select pin level
// RULE_13 - data line is input plus pull-low output, never driven high
// RULE_14 - clock line is an input only
// RULE_15 - the controller makes the clock, at most 1 MHz, and starts transfers
// RULE_16 - both serial inputs are spike filtered before any detection
// RULE_17 - both lines rest high and released when no transfer runs
// RULE_18 - enable rising starts soft-start; enable falling turns outputs off
// RULE_19 - interrupt pin is active low open drain, released when no fault
// RULE_20 - each channel is switched on or off by a register write
// RULE_21 - each accepted byte is acknowledged by pulling data low for the ninth clock
// RULE_22 - write frame: start, address+0, register index, data, stop
// RULE_23 - read frame: write of the index, repeated start, address+1, data, stop
// RULE_24 - interrupt stays asserted while unmasked latched faults remain unread
// RULE_25 - on address mismatch no acknowledge; ignore the bus until start or stop
`timescale 1ns/100ps
module camera_protector_i2c_target #(
  parameter int SPIKE_FILTER_CYCLES = prot_i2c_pkg::SPIKE_CYCLES,
  parameter logic [7:0] IDENT_VALUE = 8'h3C // arbitrary value
) (
  // clock, reset, enable
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic clkEn,
  // serial bus pins
  input wire logic sclIn,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  // straps and enable pin
  input wire logic addrSel,
  input wire logic enIn,
  // fault sources from the analog side
  input wire logic [7:0] devFault,
  input wire logic [15:0] chanFault,
  // interrupt pin
  output logic intOut,
  output logic intOe,
  // channel control
  output logic [prot_i2c_pkg::NUM_CHAN-1:0] chanOn,
  output logic softStart,
  output logic outputsOff,
  output logic busBusy
);
  import prot_i2c_pkg::*;

  typedef struct packed {
    bus_state_e state;
    // bits taken in the current byte; 8 marks the byte as complete
    logic [3:0] bitCnt;
    logic [7:0] shReg;
    logic [7:0] regPtr;
    logic rw;
    // high while this block pulls the data line low
    logic sdaLow;
    // previous filtered levels, for edge and condition detection
    logic sclPrev;
    logic sdaPrev;
    // set by a start until the next clock fall, so a stop in that pulse is ignored
    logic startHigh;
    logic enPrev;
    // one-cycle strobes towards the register block and the enable outputs, then the registered channel enables
    logic wrStb;
    logic rdStb;
    logic softStart;
    logic outOff;
    logic [NUM_CHAN-1:0] chanOn;
  } eng_s;

  eng_s r, n;
  logic [3:0] pinLvl;
  logic scl, sda, en, addrLvl;
  logic sclRise, sclFall, startCond, stopCond, enRise, enFall;
  logic [6:0] ownAddr;
  logic [7:0] rdData;
  logic [NUM_CHAN-1:0] cfgEnable;
  logic intAsserted;
  logic byteDone, addrHit, genCall;
  logic [NUM_CHAN-1:0] chanGate;

  // clock and data idle high, enable and strap low, until the filter settles
  prot_pin_filter #(
    .W(4),
    .CNT(SPIKE_FILTER_CYCLES),
    .RESET_LVL(4'h3)
  ) u_filter (
    .ref_clk(ref_clk),
    .reset(reset),
    .clkEn(clkEn),
    .rawIn({addrSel, enIn, sdaIn, sclIn}),
    .level(pinLvl)
  ); // RULE_16

  prot_regs #(
    .IDENT_VALUE(IDENT_VALUE)
  ) u_regs (
    .ref_clk(ref_clk),
    .reset(reset),
    .clkEn(clkEn),
    .wrStb(r.wrStb),
    .rdStb(r.rdStb),
    .regAddr(r.regPtr),
    .wrData(r.shReg),
    .rdData(rdData),
    .devFault(devFault),
    .chanFault(chanFault),
    .cfgEnable(cfgEnable),
    .intAsserted(intAsserted)
  );

  // the clock pin is only ever sampled; this block owns no driver that could hold it low
  assign scl = pinLvl[0]; // RULE_07 RULE_14
  assign sda = pinLvl[1];
  assign en = pinLvl[2];
  assign addrLvl = pinLvl[3];
  assign ownAddr = {ADDR_UPPER, ADDR_MID, addrLvl}; // RULE_12

  assign sclRise = scl & ~r.sclPrev;
  assign sclFall = ~scl & r.sclPrev;
  // both filtered lines carry the same delay, so their order is kept
  assign startCond = scl & r.sclPrev & ~sda & r.sdaPrev; // RULE_02
  assign stopCond = scl & r.sclPrev & sda & ~r.sdaPrev; // RULE_03
  // enable edges come from the filtered level, so a bounce inside the window gives no pulse
  assign enRise = en & ~r.enPrev;
  assign enFall = ~en & r.enPrev;
  assign byteDone = (r.bitCnt == BYTE_BITS); // RULE_05

  // the general call is refused on its own, whatever the strap makes of our address
  always_comb begin
    genCall = (r.shReg == GENERAL_CALL); // RULE_08
    addrHit = 1'b0;
    if (r.shReg[7:1] == ownAddr && !genCall) begin
      addrHit = 1'b1; // RULE_09
    end
  end

  // each channel follows its own enable bit, gated by the filtered enable pin
  for (genvar c = 0; c < NUM_CHAN; c++) begin : g_chan
    assign chanGate[c] = en & cfgEnable[c]; // RULE_20
  end

  always_comb begin
    n = r;
    n.sclPrev = scl;
    n.sdaPrev = sda;
    n.enPrev = en;
    n.wrStb = 1'b0;
    n.rdStb = 1'b0;
    n.softStart = enRise; // RULE_18
    n.outOff = enFall; // RULE_18
    n.chanOn = chanGate; // RULE_20

    if (startCond) begin
      // a repeated start lands here from any state, without a stop first
      n.state = BUS_ADDR; // RULE_04
      n.bitCnt = 4'h0; // RULE_11
      n.shReg = 8'h00;
      n.sdaLow = 1'b0;
      n.startHigh = 1'b1;
    end else if (stopCond && !r.startHigh) begin
      n.state = BUS_IDLE; // RULE_06
      n.bitCnt = 4'h0;
      n.sdaLow = 1'b0; // RULE_17
    end else if (sclRise) begin
      case (r.state)
        BUS_ADDR, BUS_REG, BUS_WDATA: begin
          if (r.bitCnt < BYTE_BITS) begin
            n.shReg = {r.shReg[6:0], sda}; // RULE_01
            n.bitCnt = r.bitCnt + 4'h1; // RULE_05
          end
        end

        BUS_RDATA: begin
          n.bitCnt = r.bitCnt + 4'h1; // RULE_05
        end

        default: begin
        end
      endcase
    end else if (sclFall) begin
      n.startHigh = 1'b0;
      case (r.state)
        BUS_ADDR: begin
          if (byteDone) begin
            if (addrHit) begin
              n.rw = r.shReg[0]; // RULE_09
              n.sdaLow = 1'b1; // RULE_21
              n.state = BUS_ADDR_ACK;
            end else begin
              n.state = BUS_IGNORE; // RULE_25
            end
          end
        end

        BUS_ADDR_ACK: begin
          n.bitCnt = 4'h0;
          if (r.rw) begin
            // read: first bit goes out on this same falling edge
            // the byte is copied here; its read-clear lands a cycle later, after the copy
            n.sdaLow = ~rdData[7]; // RULE_10
            n.shReg = {rdData[6:0], 1'b0};
            n.rdStb = 1'b1; // RULE_23
            n.state = BUS_RDATA;
          end else begin
            // write: the next byte names the register
            n.sdaLow = 1'b0;
            n.state = BUS_REG; // RULE_22
          end
        end

        BUS_REG: begin
          if (byteDone) begin
            // index kept for the data byte and for a following read
            n.regPtr = r.shReg;
            n.sdaLow = 1'b1; // RULE_21
            n.state = BUS_REG_ACK;
          end
        end

        BUS_REG_ACK: begin
          n.sdaLow = 1'b0;
          n.bitCnt = 4'h0;
          n.state = BUS_WDATA;
        end

        BUS_WDATA: begin
          if (byteDone) begin
            n.sdaLow = 1'b1; // RULE_21
            n.wrStb = 1'b1; // RULE_22
            n.state = BUS_WDATA_ACK;
          end
        end

        BUS_WDATA_ACK: begin
          // further data bytes land in the following registers
          n.sdaLow = 1'b0;
          n.bitCnt = 4'h0;
          n.regPtr = r.regPtr + 8'h01;
          n.state = BUS_WDATA;
        end

        BUS_RDATA: begin
          if (byteDone) begin
            n.sdaLow = 1'b0;
            n.state = BUS_RDATA_ACK;
          end else begin
            n.sdaLow = ~r.shReg[7]; // RULE_13
            n.shReg = {r.shReg[6:0], 1'b0};
          end
        end

        BUS_RDATA_ACK: begin
          // a single byte per read frame; the rest waits for stop or start
          n.state = BUS_IGNORE;
        end

        BUS_IGNORE: begin
          // not addressed, or read byte done: stay off the line until the next start or stop
          n.sdaLow = 1'b0; // RULE_25
        end

        default: begin
          n.sdaLow = 1'b0;
        end
      endcase
    end
  end

  // clkEn low holds every bit of state, filters and strobes included
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      r <= '{state: BUS_IDLE, bitCnt: 4'h0, shReg: 8'h00, regPtr: 8'h00, rw: 1'b0,
             sdaLow: 1'b0, sclPrev: 1'b1, sdaPrev: 1'b1, startHigh: 1'b0, enPrev: 1'b0,
             wrStb: 1'b0, rdStb: 1'b0, softStart: 1'b0, outOff: 1'b0, chanOn: '0};
    end else if (clkEn) begin
      r <= n;
    end
  end

  // open drain: the driven value is always low, only the enable moves
  assign sdaOut = 1'b0; // RULE_13
  assign sdaOe = r.sdaLow; // RULE_13
  assign intOut = 1'b0; // RULE_19
  // the pin enable comes straight from a register, so the interrupt line cannot glitch
  assign intOe = intAsserted; // RULE_19
  assign chanOn = r.chanOn;
  // enable pulses last one cycle each
  assign softStart = r.softStart;
  assign outputsOff = r.outOff;
  assign busBusy = (r.state != BUS_IDLE);
endmodule // camera_protector_i2c_target

/* test/prot_i2c_assertions.sv */
// concurrent checks on the serial target's ports
`timescale 1ns/100ps
module prot_i2c_assertions #(
  parameter int SPIKE_FILTER_CYCLES = 2
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // serial pins and enable pin
  input wire logic sclIn,
  input wire logic sdaOut,
  input wire logic sdaOe,
  input wire logic enIn,
  // faults and interrupt
  input wire logic [7:0] devFault,
  input wire logic intOut,
  input wire logic intOe,
  // channel control
  input wire logic [prot_i2c_pkg::NUM_CHAN-1:0] chanOn,
  input wire logic softStart,
  input wire logic outputsOff,
  input wire logic busBusy
);
  import prot_i2c_pkg::*;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (reset);
  property p_sda_low; sdaOe |-> !sdaOut; endproperty
  a_sda_low: assert property (p_sda_low) else $error("data driven high");
  // eight cycles into a high phase the filtered clock has settled, so nothing may move
  property p_ack_hold; sclIn && $past(sclIn, 8) |-> $stable(sdaOe); endproperty
  a_ack_hold: assert property (p_ack_hold) else $error("data moved in clock high");
  property p_idle; !busBusy |-> !sdaOe; endproperty
  a_idle: assert property (p_idle) else $error("data held while idle");
  property p_soft; $rose(enIn) |-> ##[2:20] softStart; endproperty
  a_soft: assert property (p_soft) else $error("no soft start");
  property p_pulse; softStart |=> !softStart; endproperty
  a_pulse: assert property (p_pulse) else $error("soft start too long");
  property p_off; $fell(enIn) |-> ##[2:20] outputsOff ##[0:2] (chanOn == '0); endproperty
  a_off: assert property (p_off) else $error("outputs not turned off");
  property p_int_low; intOe |-> !intOut; endproperty
  a_int_low: assert property (p_int_low) else $error("interrupt driven high");
  property p_int_set; $rose(devFault[ST_ISET]) |-> ##[1:4] intOe; endproperty
  a_int_set: assert property (p_int_set) else $error("interrupt missing");
  property p_int_keep; intOe && !busBusy |=> intOe; endproperty
  a_int_keep: assert property (p_int_keep) else $error("interrupt dropped unread");
endmodule // prot_i2c_assertions

bind camera_protector_i2c_target prot_i2c_assertions #(
  .SPIKE_FILTER_CYCLES(SPIKE_FILTER_CYCLES)
) u_chk (
  .ref_clk(ref_clk), .reset(reset), .sclIn(sclIn), .sdaOut(sdaOut), .sdaOe(sdaOe),
  .enIn(enIn), .devFault(devFault), .intOut(intOut), .intOe(intOe), .chanOn(chanOn),
  .softStart(softStart), .outputsOff(outputsOff), .busBusy(busBusy)
);

/* test/prot_ctrl_model.sv */
// bus controller model: makes the serial clock and pulls data low
`timescale 1ns/100ps
module prot_ctrl_model (
  // clock
  input wire logic ref_clk,
  // bus lines
  input wire logic sdaLine,
  output logic sclDrv,
  output logic sdaLow
);
  initial begin
    sclDrv = 1'b1;
    sdaLow = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  // 125 ns bit: data moves mid-low, sampled mid-high
  task automatic bitCycle(input logic b, output logic s);
    sclDrv <= 1'b0;
    tick(6);
    sdaLow <= ~b;
    tick(7);
    sclDrv <= 1'b1;
    tick(6);
    s = sdaLine;
    tick(6);
  endtask
  task automatic startCond();
    // a line still held low, by us or by a target's ack, is released in a low phase first
    if (!sclDrv || !sdaLine) begin
      sclDrv <= 1'b0;
      tick(6);
      sdaLow <= 1'b0;
      tick(7);
      sclDrv <= 1'b1;
      tick(12);
    end
    sdaLow <= 1'b1;
    tick(12);
  endtask
  task automatic stopCond();
    sclDrv <= 1'b0;
    tick(6);
    sdaLow <= 1'b1;
    tick(7);
    sclDrv <= 1'b1;
    tick(12);
    sdaLow <= 1'b0;
    tick(12);
  endtask
  // a short count leaves the byte unfinished, with no ack clock
  task automatic sendBits(input logic [7:0] v, input int n, output logic ack);
    logic s;
    for (int i = 7; i > 7 - n; i--) bitCycle(v[i], s);
    if (n == 8) bitCycle(1'b1, s);
    ack = ~s;
  endtask
  task automatic readByte(output logic [7:0] v);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bitCycle(1'b1, s);
      v[i] = s;
    end
    bitCycle(1'b1, s);
  endtask
endmodule // prot_ctrl_model

/* test/tb_top.sv */
// self-checking bench for the serial target port
`timescale 1ns/100ps
`define CHK(a, e, m) begin nTests++; if ((a) !== (e)) begin errCount++; \
  $display("[FAIL] %0t %s", $time, m); end end
module tb_top;
  import prot_i2c_pkg::*;
  localparam logic [7:0] IDV = 8'hA6; // arbitrary value
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic addrSel = 1'b0;
  logic enIn = 1'b0;
  logic clkEn = 1'b1;
  logic [7:0] devFault = 8'h00;
  logic [15:0] chanFault = 16'h0000;
  logic sclDrv, sdaLow, sdaOut, sdaOe, intOut, intOe, softStart, outputsOff, busBusy;
  logic [3:0] chanOn;
  logic [7:0] got;
  int errCount = 0;
  int nTests = 0;
  int cycleCount = 0;
  // open-drain wires with pull-ups
  wire sdaLine = !(sdaLow || (sdaOe && !sdaOut));
  wire intLevel = !(intOe && !intOut);
  always #2.5 ref_clk = ~ref_clk;
  prot_ctrl_model u_ctrl (.ref_clk(ref_clk), .sdaLine(sdaLine), .sclDrv(sclDrv),
    .sdaLow(sdaLow));
  camera_protector_i2c_target #(.SPIKE_FILTER_CYCLES(2), .IDENT_VALUE(IDV)) u_dut (
    .ref_clk(ref_clk), .reset(reset), .clkEn(clkEn), .sclIn(sclDrv), .sdaIn(sdaLine),
    .sdaOut(sdaOut), .sdaOe(sdaOe), .addrSel(addrSel), .enIn(enIn), .devFault(devFault),
    .chanFault(chanFault), .intOut(intOut), .intOe(intOe), .chanOn(chanOn),
    .softStart(softStart), .outputsOff(outputsOff), .busBusy(busBusy));
  task automatic giveVerdict();
    $display("mismatches %0d of %0d checks", errCount, nTests);
    if (errCount == 0 && nTests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // whole write frame, or index write plus repeated-start read
  task automatic frame(input logic [7:0] adr, input logic [7:0] idx, input logic [7:0] dat,
                       input logic rd, output logic [7:0] q);
    logic k;
    u_ctrl.startCond();
    u_ctrl.sendBits(adr, 8, k);
    `CHK(k, 1'b1, "address not acknowledged")
    u_ctrl.sendBits(idx, 8, k);
    `CHK(k, 1'b1, "index not acknowledged")
    if (rd) begin
      u_ctrl.startCond();
      u_ctrl.sendBits(adr | 8'h01, 8, k);
      `CHK(k, 1'b1, "read address not acknowledged")
      u_ctrl.readByte(q);
    end else begin
      u_ctrl.sendBits(dat, 8, k);
      `CHK(k, 1'b1, "data not acknowledged")
    end
    u_ctrl.stopCond();
  endtask
  task automatic testEnable();
    enIn <= 1'b1;
    u_ctrl.tick(20);
    `CHK(chanOn, 4'hF, "channels not on")
    frame(8'h50, REG_CONFIG, 8'h0A, 1'b0, got);
    `CHK(chanOn, 4'hA, "channel write")
    `CHK(busBusy, 1'b0, "busy after stop")
    enIn <= 1'b0;
    u_ctrl.tick(20);
    `CHK(chanOn, 4'h0, "channels not off")
    enIn <= 1'b1;
  endtask
  task automatic testAddress();
    logic k;
    addrSel <= 1'b1;
    u_ctrl.tick(20);
    u_ctrl.startCond();
    u_ctrl.sendBits(8'h50, 8, k);
    `CHK(k, 1'b0, "foreign address acknowledged")
    u_ctrl.sendBits(8'h52, 8, k);
    `CHK(k, 1'b0, "byte after mismatch acknowledged")
    u_ctrl.startCond();
    u_ctrl.sendBits(GENERAL_CALL, 8, k);
    `CHK(k, 1'b0, "general call acknowledged")
    frame(8'h52, REG_IDENT, 8'h00, 1'b1, got);
    `CHK(got, IDV, "read at pin-high address")
    addrSel <= 1'b0;
  endtask
  task automatic testAbort();
    logic k;
    u_ctrl.tick(20);
    u_ctrl.startCond();
    u_ctrl.sendBits(8'h50, 4, k);
    u_ctrl.stopCond();
    `CHK(busBusy, 1'b0, "busy after early stop")
    frame(8'h50, REG_IDENT, 8'h00, 1'b1, got);
    `CHK(got, IDV, "read after abort")
  endtask
  task automatic testInterrupt();
    devFault <= 8'h20;
    u_ctrl.tick(5);
    `CHK(intLevel, 1'b0, "interrupt not low")
    devFault <= 8'h00;
    u_ctrl.tick(10);
    `CHK(intLevel, 1'b0, "interrupt dropped before read")
    frame(8'h50, REG_STAT0, 8'h00, 1'b1, got);
    `CHK(got, 8'h20, "device status")
    `CHK(intLevel, 1'b1, "interrupt kept after read")
    frame(8'h50, REG_MASK, 8'h04, 1'b0, got);
    chanFault <= 16'h0004;
    u_ctrl.tick(10);
    `CHK(intLevel, 1'b1, "masked fault raised interrupt")
    frame(8'h50, REG_MASK, 8'h00, 1'b0, got);
    `CHK(intLevel, 1'b0, "unmasked fault silent")
    chanFault <= 16'h0000;
    frame(8'h50, REG_STAT1, 8'h00, 1'b1, got);
    `CHK(got, 8'h04, "channel status")
    `CHK(intLevel, 1'b1, "interrupt kept after channel read")
  endtask
  // a frame sent while the clock enable is low must leave no trace
  task automatic testFreeze();
    logic k;
    clkEn <= 1'b0;
    u_ctrl.tick(2);
    u_ctrl.startCond();
    u_ctrl.sendBits(8'h50, 8, k);
    `CHK(k, 1'b0, "acknowledged while frozen")
    `CHK(busBusy, 1'b0, "state moved while frozen")
    u_ctrl.stopCond();
    clkEn <= 1'b1;
    u_ctrl.tick(20);
    frame(8'h50, REG_IDENT, 8'h00, 1'b1, got);
    `CHK(got, IDV, "read after freeze")
  endtask
  // whole run is some 8.4k cycles
  always @(posedge ref_clk) begin
    cycleCount <= cycleCount + 1;
    if (cycleCount == 60000) begin
      errCount++;
      giveVerdict();
    end
  end
  initial begin
    repeat (10) @(posedge ref_clk);
    reset <= 1'b0;
    testEnable();
    testAddress();
    testAbort();
    testFreeze();
    testInterrupt();
    giveVerdict();
  end
endmodule // tb_top
